// file: src/reset_gen_defs.vh
// Constants for the reset source generation block
// Operation
// - Failed option check raises option-fail source
// - Retry on failure; third failure enters emulated sleep
// - Emulated failure sleep forces readout protection
// - Debug reset request asserts system reset only
// - JTAG reset resets only test access port
// - JTAG reset ignored in serial or disabled mode
// - Sleep reset held entry through power-good
// - Emulated deep sleep keeps core power applied
// - One cause bit; option fail keeps original
// - Lockup flags and halts, applies no reset
// - Power-on output resets core and debug
// - System output spares debug components
// - Debug access output resets bus access port
// - Always-on output resets retained peripherals
// - Core peripheral output resets core peripherals
// - HV or awake LV asserts all five
// - Non-emulated sleep LV or sleep cycle spares always-on
// - Pin spares debug access; watchdog/software three
// - Option fail, emulated sleep, debug reset masks
// - Cause bits placed at bits zero to seven
// - Cause resets to one; bit zero reads one
// - Watchdog expiry raises watchdog source
// - Software request raises software source
`ifndef RESET_GEN_DEFS_VH
`define RESET_GEN_DEFS_VH

// Register byte addresses
`define ADDR_CAUSE        32'h4000002c
`define ADDR_STATUS       32'h40000030
`define ADDR_CONTROL      32'h40000034

// Cause record field positions and reset value
`define CAUSE_HV          0
`define CAUSE_LV          1
`define CAUSE_PIN         2
`define CAUSE_WDOG        3
`define CAUSE_SW          4
`define CAUSE_WAKE        5
`define CAUSE_OPTFAIL     6
`define CAUSE_LOCKUP      7
`define CAUSE_RESET       8'h01

// Reset output mask positions
`define OUT_POR           4
`define OUT_SYS           3
`define OUT_DAP           2
`define OUT_AON           1
`define OUT_CORE          0

// Output masks per source
`define MASK_ALL          5'h1f
`define MASK_SLEEP        5'h1d
`define MASK_PIN          5'h1b
`define MASK_WDOG_SW      5'h0b
`define MASK_OPTFAIL      5'h19
`define MASK_EMU          5'h09
`define MASK_DEBUG        5'h08

// Option check retry limit
`define OPT_FAIL_LIMIT    2'h3

// Least reset pulse width and clock rate
`define RST_HOLD_NS       20
`define MCLK_MHZ          250
`define RST_HOLD_CYC      ((`RST_HOLD_NS * `MCLK_MHZ + 999) / 1000)

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif

// file: src/reset_source_generation.v
// Reset source collection, domain reset generation and cause record
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "reset_gen_defs.vh"

module reset_source_generation (
   input  wire        mclk,
   input  wire        resetn,
   input  wire        highVoltagePowerDetect,
   input  wire        lowVoltagePowerDetect,
   input  wire        externalResetPinN,
   input  wire        watchdogExpired,
   input  wire        softwareResetRequest,
   input  wire        debugResetRequest,
   input  wire        optionCheckValid,
   input  wire        optionCheckFail,
   input  wire        sleepEntryRequest,
   input  wire        sleepWakeRequest,
   input  wire        lvPowerGood,
   input  wire        lockupEntry,
   input  wire        jtagResetN,
   input  wire        debugSerialMode,
   input  wire        debugPortDisabled,
   output wire        powerOnResetOut,
   output wire        systemResetOut,
   output wire        debugAccessResetOut,
   output wire        alwaysOnPeriphReset,
   output wire        corePeriphReset,
   output reg         tapReset,
   output wire        readoutProtectForce,
   output wire        coreHalt,
   output wire        coreDomainPowerOff,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   // -----------------------------------------------------------------
   // Constants and states
   // -----------------------------------------------------------------
   localparam integer HOLD_INT = `RST_HOLD_CYC;
   localparam [7:0] HOLD_CYC  = HOLD_INT[7:0];
   localparam [4:0] ST_AWAKE  = 5'h01;
   localparam [4:0] ST_DOWN   = 5'h02;
   localparam [4:0] ST_SLEEP  = 5'h04;
   localparam [4:0] ST_WAKE   = 5'h08;
   localparam [4:0] ST_EMU    = 5'h10;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   reg        rstSync1;
   reg        rstSync2;
   wire       rstN;
   reg  [4:0] state_reg;
   reg  [4:0] state_next;
   reg  [4:0] holdMask_reg;
   reg  [7:0] holdCnt_reg;
   reg  [4:0] eventMask;
   reg  [7:1] cause_reg;
   reg  [7:1] cause_next;
   reg  [1:0] failCnt_reg;
   reg        protect_reg;
   reg        lockup_reg;
   reg        emuSelect_reg;
   reg        wakeDone;
   reg        emuEntry;
   wire       optFail;
   wire       optLimit;
   wire       inSleep;
   wire       sleepHeld;
   reg        awHave_reg;
   reg        wHave_reg;
   reg [31:0] awAddr_reg;
   reg [31:0] wData_reg;
   reg  [3:0] wStrb_reg;
   wire [31:0] statusWord;
   wire [31:0] causeWord;

   // -----------------------------------------------------------------
   // Reset release through two flip-flops
   // -----------------------------------------------------------------
   // First stage feeds only the second stage
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end
   assign rstN = rstSync2;

   // -----------------------------------------------------------------
   // Option byte check and retry count
   // -----------------------------------------------------------------
   assign optFail  = optionCheckValid & optionCheckFail;
   assign optLimit = optFail & (failCnt_reg == (`OPT_FAIL_LIMIT - 2'h1));

   // Count survives the resets this block generates
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         failCnt_reg <= 2'h0;
      end else if (optFail) begin
         failCnt_reg <= optLimit ? 2'h0 : failCnt_reg + 2'h1;
      end else if (optionCheckValid) begin
         failCnt_reg <= 2'h0;
      end
   end

   // -----------------------------------------------------------------
   // Deep sleep sequencing
   // -----------------------------------------------------------------
   // Next state for normal and emulated sleep
   always @* begin
      state_next = state_reg;
      wakeDone   = 1'b0;
      emuEntry   = 1'b0;
      case (state_reg)
         ST_AWAKE: begin
            if (optLimit) begin
               state_next = ST_EMU;
               emuEntry   = 1'b1;
            end else if (sleepEntryRequest) begin
               state_next = emuSelect_reg ? ST_EMU : ST_DOWN;
               emuEntry   = emuSelect_reg;
            end
         end
         ST_DOWN: begin
            state_next = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (sleepWakeRequest) begin
               state_next = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (lvPowerGood) begin
               state_next = ST_AWAKE;
               wakeDone   = 1'b1;
            end
         end
         ST_EMU: begin
            if (sleepWakeRequest) begin
               state_next = ST_AWAKE;
               wakeDone   = 1'b1;
            end
         end
         default: begin
            state_next = ST_AWAKE;
         end
      endcase
   end

   // State register
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= ST_AWAKE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign inSleep   = state_reg[2] | state_reg[1] | state_reg[3];
   assign sleepHeld = inSleep | (state_reg[0] & sleepEntryRequest & ~emuSelect_reg);
   assign coreDomainPowerOff = state_reg[2];

   // Readout protection forced while parked after failures
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         protect_reg <= 1'b0;
      end else if (optLimit) begin
         protect_reg <= 1'b1;
      end else if (state_reg[4] & sleepWakeRequest) begin
         protect_reg <= 1'b0;
      end
   end
   assign readoutProtectForce = protect_reg;

   // -----------------------------------------------------------------
   // Source to output mapping
   // -----------------------------------------------------------------
   // Union of the masks of every source active this cycle
   always @* begin
      eventMask = 5'h00;
      if (highVoltagePowerDetect) begin
         eventMask = eventMask | `MASK_ALL;
      end
      if (lowVoltagePowerDetect) begin
         eventMask = eventMask | (inSleep ? `MASK_SLEEP : `MASK_ALL);
      end
      if (!externalResetPinN) begin
         eventMask = eventMask | `MASK_PIN;
      end
      if (watchdogExpired | softwareResetRequest) begin
         eventMask = eventMask | `MASK_WDOG_SW;
      end
      if (optFail & ~optLimit) begin
         eventMask = eventMask | `MASK_OPTFAIL;
      end
      if (sleepHeld) begin
         eventMask = eventMask | `MASK_SLEEP;
      end
      if (state_reg[4] | emuEntry) begin
         eventMask = eventMask | `MASK_EMU;
      end
      if (debugResetRequest) begin
         eventMask = eventMask | `MASK_DEBUG;
      end
   end

   // Stretch each assertion to a least pulse width
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         holdMask_reg <= `MASK_ALL;
         holdCnt_reg  <= HOLD_CYC;
      end else if (eventMask != 5'h00) begin
         holdMask_reg <= (holdCnt_reg != 8'h00) ? (holdMask_reg | eventMask) : eventMask;
         holdCnt_reg  <= HOLD_CYC;
      end else if (holdCnt_reg != 8'h00) begin
         holdCnt_reg  <= holdCnt_reg - 8'h01;
      end else begin
         holdMask_reg <= 5'h00;
      end
   end

   assign powerOnResetOut     = holdMask_reg[`OUT_POR];
   assign systemResetOut      = holdMask_reg[`OUT_SYS];
   assign debugAccessResetOut = holdMask_reg[`OUT_DAP];
   assign alwaysOnPeriphReset = holdMask_reg[`OUT_AON];
   assign corePeriphReset     = holdMask_reg[`OUT_CORE];

   // Test access port reset, independent of every other source
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         tapReset <= 1'b0;
      end else begin
         tapReset <= ~jtagResetN & ~debugSerialMode & ~debugPortDisabled;
      end
   end

   // -----------------------------------------------------------------
   // Lockup flag
   // -----------------------------------------------------------------
   // Halts the core without any reset; set beats clear
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         lockup_reg <= 1'b0;
      end else if (lockupEntry) begin
         lockup_reg <= 1'b1;
      end else if (systemResetOut) begin
         lockup_reg <= 1'b0;
      end
   end
   assign coreHalt = lockup_reg;

   // -----------------------------------------------------------------
   // Cause record
   // -----------------------------------------------------------------
   // Highest priority cause of a restart, one bit; option fail adds its bit to the kept cause
   always @* begin
      cause_next = cause_reg;
      if (highVoltagePowerDetect) begin
         cause_next = 7'h00;
      end else if (lowVoltagePowerDetect) begin
         cause_next = 7'h01;
      end else if (!externalResetPinN) begin
         cause_next = 7'h02;
      end else if (watchdogExpired) begin
         cause_next = 7'h04;
      end else if (softwareResetRequest) begin
         cause_next = 7'h08;
      end else if (wakeDone) begin
         cause_next = 7'h10;
      end else if (optFail) begin
         cause_next = cause_reg | 7'h20;
      end else if (lockupEntry) begin
         cause_next = 7'h40;
      end
   end

   // Changes only on capture, never by a bus write
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         cause_reg <= 7'h00;
      end else begin
         cause_reg <= cause_next;
      end
   end
   assign causeWord = {24'h000000, cause_reg, 1'b1};

   assign statusWord = {22'h000000, failCnt_reg, 1'b0, lockup_reg,
                        protect_reg, state_reg};

   // -----------------------------------------------------------------
   // AXI4-Lite write channel
   // -----------------------------------------------------------------
   assign s_axi_awready = ~awHave_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHave_reg & ~s_axi_bvalid;

   // Hold address and data until both are present
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         awHave_reg    <= 1'b0;
         wHave_reg     <= 1'b0;
         awAddr_reg    <= 32'h00000000;
         wData_reg     <= 32'h00000000;
         wStrb_reg     <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         emuSelect_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awHave_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHave_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (awHave_reg & wHave_reg & ~s_axi_bvalid) begin
            awHave_reg   <= 1'b0;
            wHave_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awAddr_reg & 32'hfffffffc)
               `ADDR_CONTROL: begin
                  s_axi_bresp <= `RESP_OKAY;
                  if (wStrb_reg[0]) begin
                     emuSelect_reg <= wData_reg[0];
                  end
               end
               `ADDR_CAUSE, `ADDR_STATUS: begin
                  s_axi_bresp <= `RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= `RESP_DECERR;
               end
            endcase
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite read channel
   // -----------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;

   // One read in flight; data answered the cycle after address
   always @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr & 32'hfffffffc)
            `ADDR_CAUSE: begin
               s_axi_rdata <= causeWord;
               s_axi_rresp <= `RESP_OKAY;
            end
            `ADDR_STATUS: begin
               s_axi_rdata <= statusWord;
               s_axi_rresp <= `RESP_OKAY;
            end
            `ADDR_CONTROL: begin
               s_axi_rdata <= {31'h00000000, emuSelect_reg};
               s_axi_rresp <= `RESP_OKAY;
            end
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_DECERR;
            end
         endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// file: verification/reset_source_generation_props.sv
// Port-level checker for the reset source generation block
`timescale 1ns/1ps
module reset_source_generation_props (
   input wire mclk,
   input wire resetn,
   input wire highVoltagePowerDetect,
   input wire lowVoltagePowerDetect,
   input wire externalResetPinN,
   input wire watchdogExpired,
   input wire softwareResetRequest,
   input wire debugResetRequest,
   input wire optionCheckValid,
   input wire optionCheckFail,
   input wire sleepEntryRequest,
   input wire sleepWakeRequest,
   input wire lockupEntry,
   input wire jtagResetN,
   input wire debugSerialMode,
   input wire debugPortDisabled,
   input wire powerOnResetOut,
   input wire systemResetOut,
   input wire debugAccessResetOut,
   input wire alwaysOnPeriphReset,
   input wire corePeriphReset,
   input wire tapReset,
   input wire readoutProtectForce,
   input wire coreHalt,
   input wire coreDomainPowerOff
);
   reg  [1:0] upCnt;
   reg  [1:0] quietCnt;
   wire       up = upCnt == 2'h3;
   wire       quiet = !highVoltagePowerDetect && !lowVoltagePowerDetect && externalResetPinN
                 && !watchdogExpired && !softwareResetRequest && !debugResetRequest
                 && !(optionCheckValid && optionCheckFail) && !sleepEntryRequest
                 && !sleepWakeRequest;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Cycles since reset release and since the last active source
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         upCnt    <= 2'h0;
         quietCnt <= 2'h0;
      end else begin
         if (!up)
            upCnt <= upCnt + 2'h1;
         if (!quiet)
            quietCnt <= 2'h0;
         else if (quietCnt != 2'h3)
            quietCnt <= quietCnt + 2'h1;
      end
   end
   sequence threeUp;
      systemResetOut && alwaysOnPeriphReset && corePeriphReset;
   endsequence
   sequence stretched;
      systemResetOut [*4];
   endsequence
   a_tap_follows: assert property (up && !jtagResetN && !debugSerialMode
      && !debugPortDisabled |=> tapReset) else $error("tap reset missed");
   a_tap_ignored: assert property (debugSerialMode || debugPortDisabled
      |=> !tapReset) else $error("tap reset not ignored");
   a_lockup_halts: assert property (up && lockupEntry |=> coreHalt)
      else $error("lockup flag missing");
   a_lockup_no_reset: assert property (up && quiet && quietCnt == 2'h3
      && !systemResetOut |=> !systemResetOut) else $error("reset without a source");
   a_wdog_mask: assert property (watchdogExpired || softwareResetRequest
      |-> ##[1:2] threeUp) else $error("watchdog or software mask wrong");
   a_hold_stretch: assert property (watchdogExpired |-> ##2 stretched)
      else $error("reset released too soon");
   a_hv_all: assert property (highVoltagePowerDetect |-> ##[1:2] threeUp
      ##0 (powerOnResetOut && debugAccessResetOut)) else $error("power-on mask wrong");
   a_pin_mask: assert property (!externalResetPinN |-> ##[1:2] threeUp
      ##0 powerOnResetOut) else $error("pin mask wrong");
   a_debug_sys: assert property (debugResetRequest |-> ##[1:2] systemResetOut)
      else $error("debug reset missing");
   a_option_mask: assert property (optionCheckValid && optionCheckFail
      |-> ##[1:2] systemResetOut && corePeriphReset) else $error("option mask wrong");
   a_protect_held: assert property (readoutProtectForce && $past(readoutProtectForce)
      |-> systemResetOut && corePeriphReset) else $error("emulated sleep not held");
   a_sleep_held: assert property (coreDomainPowerOff && $past(coreDomainPowerOff)
      |-> powerOnResetOut && systemResetOut && debugAccessResetOut && corePeriphReset)
      else $error("sleep reset not held");
endmodule
bind reset_source_generation reset_source_generation_props chk (.*);

// file: verification/reset_far_side_model.sv
// Far-side model: flash option loader and power manager
`timescale 1ns/1ps
module reset_far_side_model (
   input  wire mclk,
   output reg  optionCheckValid,
   output reg  optionCheckFail,
   output reg  sleepEntryRequest,
   output reg  sleepWakeRequest,
   output reg  lvPowerGood
);
   // Idle levels, power good while awake
   initial begin
      optionCheckValid  = 1'h0;
      optionCheckFail   = 1'h0;
      sleepEntryRequest = 1'h0;
      sleepWakeRequest  = 1'h0;
      lvPowerGood       = 1'h1;
   end
   // One option check result; fail line inverted once released
   task check(input f);
      begin
         optionCheckValid <= 1'h1;
         optionCheckFail  <= f;
         @(posedge mclk);
         optionCheckValid <= 1'h0;
         optionCheckFail  <= ~f;
      end
   endtask
   // Sleep entry; core power kept in emulated mode
   task sleep(input emu);
      begin
         sleepEntryRequest <= 1'h1;
         if (!emu)
            lvPowerGood <= 1'h0;
         @(posedge mclk);
         sleepEntryRequest <= 1'h0;
      end
   endtask
   // Wake pulse
   task wake;
      begin
         sleepWakeRequest <= 1'h1;
         @(posedge mclk);
         sleepWakeRequest <= 1'h0;
      end
   endtask
   // Detector reports reliable levels
   task powerGood;
      lvPowerGood <= 1'h1;
   endtask
endmodule

// file: verification/reset_source_generation_tb.sv
// Self-checking bench for the reset source generation block
`timescale 1ns/1ps
`include "reset_gen_defs.vh"
module reset_source_generation_tb;
   reg         mclk, resetn, jtagResetN, debugSerialMode, debugPortDisabled;
   reg  [6:0]  src;
   reg  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, d;
   reg  [3:0]  s_axi_wstrb;
   reg  [1:0]  r;
   reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire        optionCheckValid, optionCheckFail, sleepEntryRequest, sleepWakeRequest;
   wire        lvPowerGood, powerOnResetOut, systemResetOut, debugAccessResetOut;
   wire        alwaysOnPeriphReset, corePeriphReset, tapReset, readoutProtectForce;
   wire        coreHalt, coreDomainPowerOff, s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire        s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        highVoltagePowerDetect = src[0];
   wire        lowVoltagePowerDetect  = src[1];
   wire        externalResetPinN      = !src[2];
   wire        watchdogExpired        = src[3];
   wire        softwareResetRequest   = src[4];
   wire        debugResetRequest      = src[5];
   wire        lockupEntry            = src[6];
   wire [4:0]  outs = {powerOnResetOut, systemResetOut, debugAccessResetOut,
                       alwaysOnPeriphReset, corePeriphReset};
   integer     miscompares, samplesChecked, expCause, i;
   reset_source_generation dut (.*);
   reset_far_side_model partner (.*);
   // Clock
   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
   task cyc(input integer n);
      repeat (n) @(posedge mclk);
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samplesChecked = samplesChecked + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // Bus write: address and data offered together, each released when taken
   task wr(input [31:0] a, input [31:0] v, output [1:0] rs);
      reg pa, pw, pb;
      begin
         @(posedge mclk);
         pa = 1'h1;
         pw = 1'h1;
         pb = 1'h1;
         s_axi_awaddr  <= a;
         s_axi_wdata   <= v;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid  <= 1'h1;
         s_axi_bready  <= 1'h1;
         while (pb) begin
            @(posedge mclk);
            if (pa && s_axi_awready)
               pa = 1'h0;
            if (pw && s_axi_wready)
               pw = 1'h0;
            if (s_axi_bvalid)
               pb = 1'h0;
            rs = s_axi_bresp;
            s_axi_awvalid <= pa;
            s_axi_wvalid  <= pw;
            s_axi_bready  <= pb;
         end
      end
   endtask
   // Bus read
   task rd(input [31:0] a, output [31:0] v, output [1:0] rs);
      reg pa, pr;
      begin
         @(posedge mclk);
         pa = 1'h1;
         pr = 1'h1;
         s_axi_araddr  <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready  <= 1'h1;
         while (pr) begin
            @(posedge mclk);
            if (pa && s_axi_arready)
               pa = 1'h0;
            if (s_axi_rvalid)
               pr = 1'h0;
            v  = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_arvalid <= pa;
            s_axi_rready  <= pr;
         end
      end
   endtask
   task rdc;
      begin
         rd(`ADDR_CAUSE, d, r);
         chk(d, expCause);
         chk(r, 2'h0);
      end
   endtask
   function [4:0] emask(input integer k);
      case (k)
         0, 1:    emask = 5'h1f;
         2:       emask = 5'h1b;
         3, 4:    emask = 5'h0b;
         default: emask = 5'h08;
      endcase
   endfunction
   // Hold one source for a random span, compare masks, then release
   task fire(input integer k);
      begin
         src[k] <= 1'h1;
         cyc(2 + $urandom % 3);
         chk(outs, emask(k));
         src[k] <= 1'h0;
         cyc(12);
         chk(outs, 5'h00);
      end
   endtask
   task conclude;
      begin
         $display("compared %0d mismatched %0d", samplesChecked, miscompares);
         if (miscompares == 0 && samplesChecked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // Hang guard
   initial begin
      #40000;
      miscompares = miscompares + 1;
      conclude;
   end
   // Main sequence
   initial begin
      miscompares = 0;
      samplesChecked = 0;
      i = $urandom(32'h6965);
      {resetn, src, debugSerialMode, debugPortDisabled} = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
      s_axi_wstrb = 4'hf;
      jtagResetN = 1'h1;
      expCause = 1;
      cyc(3);
      chk(outs, 5'h1f);
      resetn <= 1'h1;
      cyc(14);
      chk(outs, 5'h00);
      rdc;
      for (i = 5; i >= 0; i = i - 1) begin
         fire(i);
         if (i < 5)
            expCause = (i == 0) ? 1 : (1 | (1 << i));
         rdc;
      end
      src[6] <= 1'h1;
      cyc(1);
      src[6] <= 1'h0;
      cyc(3);
      chk(coreHalt, 1'h1);
      chk(outs, 5'h00);
      expCause = 8'h81;
      rdc;
      fire(3);
      chk(coreHalt, 1'h0);
      expCause = 8'h09;
      wr(`ADDR_CAUSE, $urandom, r);
      chk(r, 2'h0);
      rdc;
      rd(32'h40000040, d, r);
      chk(r, 2'h3);
      chk(d, 32'h0);
      jtagResetN <= 1'h0;
      cyc(3);
      chk({tapReset, outs}, 6'h20);
      debugSerialMode <= 1'h1;
      cyc(3);
      chk(tapReset, 1'h0);
      debugSerialMode <= 1'h0;
      debugPortDisabled <= 1'h1;
      cyc(3);
      chk(tapReset, 1'h0);
      jtagResetN <= 1'h1;
      debugPortDisabled <= 1'h0;
      cyc(3);
      for (i = 0; i < 5; i = i + 1) begin
         partner.check(i != 1);
         cyc(3);
         chk(outs, (i == 1) ? 5'h00 : (i == 4) ? 5'h09 : 5'h19);
         chk(readoutProtectForce, i == 4);
         if (i < 4) begin
            cyc(10);
            expCause = (i == 1) ? expCause : (expCause | 8'h40);
            rdc;
         end
      end
      rd(`ADDR_STATUS, d, r);
      chk(d, 32'h30);
      partner.wake;
      cyc(2);
      chk(readoutProtectForce, 1'h0);
      cyc(12);
      chk(outs, 5'h00);
      expCause = 8'h21;
      rdc;
      partner.sleep(1'h0);
      cyc(3);
      chk({coreDomainPowerOff, outs}, 6'h3d);
      src[1] <= 1'h1;
      cyc(3);
      chk(outs, 5'h1d);
      src[1] <= 1'h0;
      partner.wake;
      cyc(1 + $urandom % 6);
      chk(outs, 5'h1d);
      partner.powerGood;
      cyc(12);
      chk(outs, 5'h00);
      rdc;
      wr(`ADDR_CONTROL, 32'h1, r);
      chk(r, 2'h0);
      rd(`ADDR_CONTROL, d, r);
      chk(d, 32'h1);
      partner.sleep(1'h1);
      cyc(3);
      chk({coreDomainPowerOff, outs}, 6'h09);
      partner.wake;
      cyc(12);
      chk(outs, 5'h00);
      rdc;
      conclude;
   end
endmodule
